// File: hdl/adccs_ctrl.sv
/*
  Control and status logic of a successive-approximation converter:
  end flag, interrupt enable, start bit, single/scan sequencing and the
  three start sources. The analogue core is outside.
  Assumes: software access as one-cycle strobes on core_clk; the core
  answers each conv_go with one conv_done pulse on core_clk; timer
  trigger, standby and module-stop come from core_clk logic.
*/
module adccs_ctrl
  import adccs_pkg::*;
(
  input  wire logic              core_clk,           // 200 MHz clock
  input  wire logic              srst,               // Sync reset, high
  input  wire logic              sw_wr,              // Byte write strobe
  input  wire logic [CSR_W-1:0]  sw_wdata,           // Written byte
  input  wire logic              sw_rd,              // Byte read strobe
  input  wire logic [CHAN_W-1:0] chan_select,        // Channel / scan top
  input  wire logic              timer_trig,         // Timer start pulse
  input  wire logic              ext_conv_trigger_n, // Start pin, low
  input  wire logic              standby,            // Standby entry
  input  wire logic              module_stop,        // Module-stop state
  input  wire logic              xfer_irq_active,    // Xfer run by irq
  input  wire logic              xfer_result_rd,     // Xfer reads result
  input  wire logic              conv_done,          // Core finished
  output logic                   conv_go,            // Start core pulse
  output logic [CHAN_W-1:0]      conv_chan,          // Channel to convert
  output logic [CSR_W-1:0]       csr_rdata,          // Status byte
  output logic                   conv_end_flag,      // End flag
  output logic                   conv_end_irq_enable, // Irq enable
  output logic                   conv_start,         // Start/busy bit
  output logic                   scan_mode,          // Scan mode bit
  output logic                   conv_end_irq        // End interrupt req
);

  // ==========================================================
  // State
  typedef struct packed {
    adccs_state_t      state;
    logic              flag;
    logic              flag_seen;
    logic              ie;
    logic              start;
    logic              scan;
    logic [CHAN_W-1:0] chan;
    logic              go;
    logic              irq;
    logic [CSR_W-1:0]  rdata;
  } adccs_ctrl_t;

  adccs_ctrl_t c_reg;
  adccs_ctrl_t c_next;

  logic ext_fall;

  // Pin passes three flops (two-flop sync, registered edge) before use
  adccs_trig_sync u_trig_sync (
    .core_clk           (core_clk),
    .srst               (srst),
    .ext_conv_trigger_n (ext_conv_trigger_n),
    .trig_fall          (ext_fall)
  );

  // Builds the readable status byte
  function automatic logic [CSR_W-1:0] pack_csr(
    input logic flag,
    input logic ie,
    input logic start,
    input logic scan
  );
    logic [CSR_W-1:0] b;
    b            = '0;
    b[FLAG_BIT]  = flag;
    b[IE_BIT]    = ie;
    b[START_BIT] = start;
    b[SCAN_BIT]  = scan;
    return b;
  endfunction : pack_csr

  // ==========================================================
  // Next state
  logic sw_start;
  logic sw_stop;
  logic hw_stop;
  logic start_req;
  logic stop_req;
  logic last_chan;
  logic set_flag;
  logic clr_flag;

  always_comb begin
    c_next    = c_reg;
    set_flag  = 1'b0;
    c_next.go = 1'b0;

    // ==========================================================
    // Start and stop requests
    // Any of the three sources starts an idle converter
    sw_start  = sw_wr & sw_wdata[START_BIT];
    start_req = sw_start | timer_trig | ext_fall;
    // Software clear, standby and module-stop all end a conversion;
    // a stop in the same cycle as a start wins
    sw_stop   = sw_wr & ~sw_wdata[START_BIT];
    hw_stop   = standby | module_stop;
    stop_req  = sw_stop | hw_stop;

    // A pass ends at the top channel, or beyond it when software
    // lowered the top channel while the pass was under way
    last_chan = (c_reg.chan >= chan_select);

    // ==========================================================
    // Software-written bits
    if (sw_wr) begin
      c_next.ie = sw_wdata[IE_BIT];
      // Mode is written as is; software keeps it stable while busy
      c_next.scan = sw_wdata[SCAN_BIT];
    end

    // ==========================================================
    // Sequencer
    case (c_reg.state)
      ADCCS_IDLE: begin
        if (start_req && !stop_req) begin
          c_next.start = 1'b1;
          c_next.chan  = c_next.scan ? CHAN_RST : chan_select;
          c_next.go    = 1'b1;
          c_next.state = ADCCS_CONV;
        end
      end
      ADCCS_CONV: begin
        if (stop_req) begin
          c_next.start = 1'b0;
          c_next.state = ADCCS_IDLE;
        end else if (conv_done) begin
          if (!c_reg.scan) begin
            set_flag     = 1'b1;
            c_next.start = 1'b0;
            c_next.state = ADCCS_IDLE;
          end else if (last_chan) begin
            set_flag     = 1'b1;
            c_next.chan  = CHAN_RST;
            c_next.go    = 1'b1;
          end else begin
            c_next.chan  = c_reg.chan + 1'b1;
            c_next.go    = 1'b1;
          end
        end
      end
      default: begin
        c_next.start = 1'b0;
        c_next.state = ADCCS_IDLE;
      end
    endcase

    // ==========================================================
    // End flag, read arming and interrupt request
    // Flag read as 1 arms the software clear
    if (sw_rd && c_reg.flag) begin
      c_next.flag_seen = 1'b1;
    end
    clr_flag = (sw_wr && !sw_wdata[FLAG_BIT] && c_reg.flag_seen)
             || (xfer_irq_active && xfer_result_rd);
    if (sw_wr) begin
      c_next.flag_seen = 1'b0;
    end
    // A flag cleared by any means must be read as 1 again before a
    // write of 0 may clear the next one
    if (clr_flag && !set_flag) begin
      c_next.flag_seen = 1'b0;
    end

    // A new end event outranks a clear in the same cycle
    if (set_flag) begin
      c_next.flag = 1'b1;
    end else if (clr_flag) begin
      c_next.flag = 1'b0;
    end

    c_next.irq   = c_next.flag & c_next.ie;
    c_next.rdata = pack_csr(c_next.flag, c_next.ie, c_next.start,
                            c_next.scan);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      c_reg <= '{state:     ADCCS_IDLE,
                 flag:      FLAG_RST,
                 flag_seen: 1'b0,
                 ie:        IE_RST,
                 start:     START_RST,
                 scan:      SCAN_RST,
                 chan:      CHAN_RST,
                 go:        1'b0,
                 irq:       1'b0,
                 rdata:     pack_csr(FLAG_RST, IE_RST, START_RST,
                                     SCAN_RST)};
    end else begin
      c_reg <= c_next;
    end
  end

  // ==========================================================
  // Outputs
  assign conv_go             = c_reg.go;
  assign conv_chan           = c_reg.chan;
  assign csr_rdata           = c_reg.rdata;
  assign conv_end_flag       = c_reg.flag;
  assign conv_end_irq_enable = c_reg.ie;
  assign conv_start          = c_reg.start;
  assign scan_mode           = c_reg.scan;
  assign conv_end_irq        = c_reg.irq;

endmodule : adccs_ctrl

// File: hdl/adccs_pkg.sv
/*
  Shared constants for the converter control and status logic: bit
  positions of the control/status byte, reset values, widths, states.
  Assumes a single 200 MHz core clock and a synchronous reset.
*/
package adccs_pkg;

  // ==========================================================
  // Control/status byte layout
  localparam int unsigned FLAG_BIT  = 7;
  localparam int unsigned IE_BIT    = 6;
  localparam int unsigned START_BIT = 5;
  localparam int unsigned SCAN_BIT  = 4;
  localparam int unsigned CSR_W     = 8;

  // ==========================================================
  // Channel numbering
  localparam int unsigned CHAN_W    = 3;

  // ==========================================================
  // Reset values
  localparam logic              FLAG_RST  = 1'h0;
  localparam logic              IE_RST    = 1'h0;
  localparam logic              START_RST = 1'h0;
  localparam logic              SCAN_RST  = 1'h0;
  localparam logic [CHAN_W-1:0] CHAN_RST  = 3'h0;
  localparam logic              PIN_IDLE  = 1'h1;

  // ==========================================================
  // Sequencer states
  typedef enum logic [0:0] {
    ADCCS_IDLE,
    ADCCS_CONV
  } adccs_state_t;

endpackage : adccs_pkg

// File: hdl/adccs_trig_sync.sv
/*
  Two-flop synchroniser for the active-low external trigger pin, with a
  falling-edge detector behind the second flop.
  Assumes the pin is asynchronous to core_clk and idles high.
*/
module adccs_trig_sync
  import adccs_pkg::*;
(
  input  wire logic core_clk,           // 200 MHz core clock
  input  wire logic srst,               // Synchronous reset, active high
  input  wire logic ext_conv_trigger_n, // Trigger pin, active low
  output logic      trig_fall           // One-cycle pulse on falling edge
);

  // ==========================================================
  // State
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic fall;
  } adccs_sync_t;

  adccs_sync_t s_reg;
  adccs_sync_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.meta = ext_conv_trigger_n;
    s_next.sync = s_reg.meta;
    s_next.last = s_reg.sync;
    s_next.fall = s_reg.last & ~s_reg.sync;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_reg <= '{meta: PIN_IDLE, sync: PIN_IDLE, last: PIN_IDLE,
                 fall: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign trig_fall = s_reg.fall;

endmodule : adccs_trig_sync

// File: verification/adccs_ctrl_properties.sv
/*
  Concurrent checks on the converter control and status ports.
  Assumes it is bound to adccs_ctrl, one clock, synchronous reset.
*/
module adccs_ctrl_properties
  import adccs_pkg::*;
(
  input wire logic             core_clk,            // Clock
  input wire logic             srst,                // Reset
  input wire logic             sw_wr,               // Write
  input wire logic [CSR_W-1:0] sw_wdata,            // Data
  input wire logic             standby,             // Standby
  input wire logic             module_stop,         // Stop
  input wire logic             xfer_irq_active,     // Xfer on
  input wire logic             xfer_result_rd,      // Xfer read
  input wire logic             conv_done,           // Done
  input wire logic             conv_go,             // Go
  input wire logic [CSR_W-1:0] csr_rdata,           // Status
  input wire logic             conv_end_flag,       // Flag
  input wire logic             conv_end_irq_enable, // Enable
  input wire logic             conv_start,          // Start
  input wire logic             scan_mode,           // Scan
  input wire logic             conv_end_irq         // Request
);
  logic stop;

  assign stop = standby | module_stop | (sw_wr & ~sw_wdata[START_BIT]);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // ==========================================================
  // Properties
  AST_CSR_MAP: assert property (csr_rdata == {conv_end_flag,
    conv_end_irq_enable, conv_start, scan_mode, 4'h0})
    else $error("status byte differs from bits");
  AST_IRQ_AND: assert property (conv_end_irq ==
    (conv_end_flag & conv_end_irq_enable)) else $error("irq not flag and ie");
  AST_IE_WR: assert property (sw_wr |=>
    conv_end_irq_enable == $past(sw_wdata[IE_BIT]))
    else $error("ie not written");
  AST_SINGLE_END: assert property (conv_start && !scan_mode &&
    conv_done && !stop |=> !conv_start && conv_end_flag)
    else $error("single end wrong");
  AST_FLAG_KEEP: assert property (conv_end_flag && !sw_wr &&
    !(xfer_irq_active && xfer_result_rd) |=> conv_end_flag)
    else $error("flag lost");
  AST_XFER_CLR: assert property (conv_end_flag && xfer_irq_active &&
    xfer_result_rd && !conv_done |=> !conv_end_flag) else $error("xfer clear");
  AST_SW_START: assert property (!conv_start && sw_wr &&
    sw_wdata[START_BIT] && !standby && !module_stop |=>
    conv_start && conv_go) else $error("write start failed");
  AST_STOP: assert property (conv_start && stop |=>
    !conv_start && !conv_go) else $error("stop ignored");
  AST_SCAN_GO: assert property (conv_start && scan_mode && conv_done &&
    !stop |=> conv_start && conv_go) else $error("scan did not continue");

  C_SINGLE: cover property (conv_start && !scan_mode && conv_done);
  C_SCAN: cover property (conv_start && scan_mode && conv_done);
  C_XFER: cover property (conv_end_flag && xfer_irq_active && xfer_result_rd);
endmodule : adccs_ctrl_properties

bind adccs_ctrl adccs_ctrl_properties u_props (.core_clk(core_clk),
  .srst(srst), .sw_wr(sw_wr), .sw_wdata(sw_wdata), .standby(standby),
  .module_stop(module_stop), .xfer_irq_active(xfer_irq_active),
  .xfer_result_rd(xfer_result_rd), .conv_done(conv_done),
  .conv_go(conv_go), .csr_rdata(csr_rdata), .conv_end_flag(conv_end_flag),
  .conv_end_irq_enable(conv_end_irq_enable), .conv_start(conv_start),
  .scan_mode(scan_mode), .conv_end_irq(conv_end_irq));

// File: verification/test_adc_control_status_logic.sv
/*
  Self-checking bench for adccs_ctrl.
  Assumes a 200 MHz clock; the bench stands in for the analogue core.
*/
module test_adc_control_status_logic;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk, srst, sw_wr, sw_rd, timer_trig, ext_conv_trigger_n;
  logic       standby, module_stop, xfer_irq_active, xfer_result_rd;
  logic       conv_done, conv_go, conv_end_irq;
  logic [7:0] sw_wdata, csr_rdata;
  logic [2:0] chan_select, conv_chan, go_d;
  logic [2:0] chans[$];
  wire  [3:0] bits;
  int         bad_count, check_count, cyc;

  adccs_ctrl dut (.core_clk(core_clk), .srst(srst), .sw_wr(sw_wr),
    .sw_wdata(sw_wdata), .sw_rd(sw_rd), .chan_select(chan_select),
    .timer_trig(timer_trig), .ext_conv_trigger_n(ext_conv_trigger_n),
    .standby(standby), .module_stop(module_stop),
    .xfer_irq_active(xfer_irq_active), .xfer_result_rd(xfer_result_rd),
    .conv_done(conv_done), .conv_go(conv_go), .conv_chan(conv_chan),
    .csr_rdata(csr_rdata), .conv_end_flag(bits[3]),
    .conv_end_irq_enable(bits[2]), .conv_start(bits[1]),
    .scan_mode(bits[0]), .conv_end_irq(conv_end_irq));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Core stand-in: done four cycles after each go; timeout counter
  always @(posedge core_clk) begin
    go_d <= srst ? 3'h0 : {go_d[1:0], conv_go === 1'b1};
    conv_done <= go_d[2] & ~srst;
    if (conv_go === 1'b1) chans.push_back(conv_chan);
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(logic [7:0] d);
    @(posedge core_clk);
    sw_wr <= 1'b1;
    sw_wdata <= d;
    @(posedge core_clk);
    sw_wr <= 1'b0;
    @(negedge core_clk);
  endtask : wr

  task automatic rdwr(logic [7:0] d);
    @(posedge core_clk);
    sw_rd <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    sw_wr <= 1'b1;
    sw_wdata <= d;
    @(posedge core_clk);
    sw_wr <= 1'b0;
    @(negedge core_clk);
  endtask : rdwr

  task automatic wflag;
    for (int i = 0; i < 20 && csr_rdata[7] !== 1'b1; i++) @(negedge core_clk);
  endtask : wflag

  task automatic test_single;
    chans.delete();
    wr(8'h60);
    chk("start", 8'h60, csr_rdata);
    wflag();
    chk("end", 8'hC0, csr_rdata);
    chk("bits", 8'h0C, {4'h0, bits});
    chk("chan", 8'h05, {5'h00, chans[0]});
    chk("irq", 8'h01, {7'h00, conv_end_irq});
    wr(8'h40);
    chk("unread clear", 8'hC0, csr_rdata);
    rdwr(8'h40);
    chk("clear", 8'h40, csr_rdata);
    chk("irq off", 8'h00, {7'h00, conv_end_irq});
  endtask : test_single

  task automatic test_timer;
    wr(8'h00);
    @(posedge core_clk);
    timer_trig <= 1'b1;
    @(posedge core_clk);
    timer_trig <= 1'b0;
    @(negedge core_clk);
    chk("timer start", 8'h20, csr_rdata);
    wflag();
    chk("masked irq", 8'h80,
        {csr_rdata[7], conv_end_irq, csr_rdata[5:0]});
    @(posedge core_clk);
    xfer_irq_active <= 1'b1;
    xfer_result_rd <= 1'b1;
    @(posedge core_clk);
    xfer_irq_active <= 1'b0;
    xfer_result_rd <= 1'b0;
    @(negedge core_clk);
    chk("xfer clear", 8'h00, csr_rdata);
  endtask : test_timer

  task automatic test_pin;
    @(posedge core_clk);
    ext_conv_trigger_n <= 1'b0;
    wflag();
    chk("pin start", 8'h80, csr_rdata);
    @(posedge core_clk);
    ext_conv_trigger_n <= 1'b1;
    rdwr(8'h00);
  endtask : test_pin

  task automatic test_scan;
    int n;
    @(posedge core_clk);
    chan_select <= 3'h2;
    chans.delete();
    wr(8'h30);
    for (int i = 0; i < 40 && chans.size() < 4; i++) @(negedge core_clk);
    for (int i = 0; i < 4; i++)
      chk("scan chan", 8'(i % 3), 8'(chans[i]));
    chk("scan pass", 8'hB0, csr_rdata);
    chk("scan bits", 8'h0B, {4'h0, bits});
    wr(8'h10);
    chk("scan stop", 8'h90, csr_rdata);
    n = chans.size();
    repeat (8) @(negedge core_clk);
    chk("go after stop", 8'(n), 8'(chans.size()));
    for (int k = 0; k < 2; k++) begin
      wr(8'h30);
      @(posedge core_clk);
      {standby, module_stop} <= k ? 2'b01 : 2'b10;
      @(posedge core_clk);
      {standby, module_stop} <= 2'b00;
      @(negedge core_clk);
      chk("halt", 8'h00, {2'b00, csr_rdata[5], 5'h00});
    end
  endtask : test_scan

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  initial begin
    srst = 1'b1;
    {sw_wr, sw_rd, timer_trig, standby, module_stop} = 5'h00;
    {xfer_irq_active, xfer_result_rd} = 2'h0;
    ext_conv_trigger_n = 1'b1;
    sw_wdata = 8'h00;
    chan_select = 3'h5;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    chk("reset", 8'h00, csr_rdata);
    test_single();
    test_timer();
    test_pin();
    test_scan();
    test_done();
  end
endmodule : test_adc_control_status_logic
